// >>> include/mcd_pkg.sv
// Constants for the magnetometer control and debounce block.
// Assumes one clock and register access at the documented offsets.
`default_nettype none
package mcd_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [7:0] OFS_THS_COUNT = 8'h5A;
	localparam logic [7:0] OFS_CTRL_ONE  = 8'h5B;
	localparam logic [7:0] OFS_CTRL_TWO  = 8'h5C;
	// ==========================================================
	// Burst address jumps
	localparam logic [7:0] ADR_FAST_LAST = 8'h05;
	localparam logic [7:0] ADR_NORM_LAST = 8'h06;
	localparam logic [7:0] ADR_MAG_FIRST = 8'h33;
	// ==========================================================
	// Control one fields
	localparam int CO_ACAL = 7;
	localparam int CO_RST  = 6;
	localparam int CO_OST  = 5;
	localparam int CO_OSLO = 2;
	localparam int CO_HMLO = 0;
	// Control two fields
	localparam int CT_AINC  = 5;
	localparam int CT_MMDIS = 4;
	localparam int CT_MMTHS = 3;
	localparam int CT_MMRST = 2;
	localparam int CT_RCLO  = 0;
	localparam logic [7:0] CT_MASK = 8'h3F;
	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_THS_COUNT = 8'h00;
	localparam logic [7:0] RST_CTRL_ONE  = 8'h00;
	localparam logic [7:0] RST_CTRL_TWO  = 8'h00;
	// ==========================================================
	// Sensor modes and degauss periods
	localparam logic [1:0] HMS_ACCEL  = 2'h0;
	localparam logic [1:0] HMS_MAG    = 2'h1;
	localparam logic [1:0] HMS_HYBRID = 2'h3;
	localparam logic [1:0] RC_EVERY = 2'h0;
	localparam logic [1:0] RC_16    = 2'h1;
	localparam logic [1:0] RC_512   = 2'h2;
	localparam int DG_CNT_W = 9;
	localparam logic [3:0] DG_MASK_16 = 4'hF;
	// Min and max restart values
	localparam logic [15:0] MIN_START = 16'h7FFF;
	localparam logic [15:0] MAX_START = 16'h8000;
endpackage
`default_nettype wire

// >>> design/mcd_top.sv
// Magnetometer control: debounce, modes, one-shot, degauss, min/max, auto-cal.
// Assumes odrTick pulses once per system data-rate cycle and the front end
// answers each measStart with one magSampleValid carrying the new sample.
`default_nettype none
module mcd_top #(
	parameter int SW = 16
) (
	input  wire logic                core_clk,
	input  wire logic                resetn,
	input  wire logic                regWr,
	input  wire logic                regRd,
	input  wire logic [7:0]          regAddr,
	input  wire logic [7:0]          regWrData,
	output logic      [7:0]          regRdData,
	output logic      [7:0]          burstAddr,
	input  wire logic                fastRead,
	input  wire logic                activeMode,
	input  wire logic                odrTick,
	input  wire logic                thsCondition,
	input  wire logic                debounceClearMode,
	input  wire logic                thsFlagClr,
	input  wire logic                magSampleValid,
	input  wire logic [2:0][SW-1:0]  magSample,
	output logic                     accelEnable,
	output logic                     magEnable,
	output logic                     hybridLayout,
	output logic      [2:0]          magOversampleRatio,
	output logic                     measStart,
	output logic                     degauss,
	output logic                     thsEvent,
	output logic      [7:0]          debounceCount,
	output logic      [2:0][SW-1:0]  magOffset,
	output logic      [2:0][SW-1:0]  magMax,
	output logic      [2:0][SW-1:0]  magMin
);
	import mcd_pkg::*;

	if (SW != 16) begin : g_chk
		$error("mcd_top: sample width must be 16");
	end

	// ==========================================================
	// Register and control state
	logic [7:0] thsCount_ff, nxt_thsCount;
	logic [7:0] ctrlOne_ff, nxt_ctrlOne;
	logic [7:0] ctrlTwo_ff, nxt_ctrlTwo;
	logic [7:0] regRdData_ff, nxt_regRdData;
	logic [7:0] burstAddr_ff, nxt_burstAddr;
	logic       half_ff, nxt_half;
	logic       prevAct_ff, nxt_prevAct;
	logic       ostBusy_ff, nxt_ostBusy;
	logic       meas_ff, nxt_meas;
	logic       degauss_ff, nxt_degauss;
	logic [DG_CNT_W-1:0] dgCnt_ff, nxt_dgCnt;
	logic [1:0] hms, rstCnt;
	logic       magOn, hybrid, sampleTick, oneShot, dgDue;

	// Mode decode
	assign hms    = ctrlOne_ff[CO_HMLO +: 2];
	assign rstCnt = ctrlTwo_ff[CT_RCLO +: 2];
	assign hybrid = (hms == HMS_HYBRID);
	assign magOn  = (hms == HMS_MAG) || hybrid;
	// Hybrid takes every other data-rate tick
	assign sampleTick = odrTick && activeMode && magOn && (!hybrid || half_ff);
	assign oneShot = ctrlOne_ff[CO_OST] && !activeMode && !ostBusy_ff;
	// Periodic degauss due at this measurement start
	always_comb begin
		unique case (rstCnt)
			RC_EVERY: dgDue = 1'b1;
			RC_16:    dgDue = (dgCnt_ff[3:0] == DG_MASK_16);
			RC_512:   dgDue = (dgCnt_ff == '1);
			default:  dgDue = 1'b0;
		endcase
	end

	// Next values of registers, pacing and one-shot control
	always_comb begin
		nxt_thsCount  = thsCount_ff;
		nxt_ctrlOne   = ctrlOne_ff;
		nxt_ctrlTwo   = ctrlTwo_ff;
		nxt_regRdData = regRdData_ff;
		nxt_burstAddr = burstAddr_ff;
		nxt_half      = hybrid ? (half_ff ^ odrTick) : 1'b0;
		nxt_prevAct   = activeMode && magOn;
		nxt_ostBusy   = ostBusy_ff;
		nxt_meas      = sampleTick || oneShot;
		nxt_dgCnt     = dgCnt_ff;
		nxt_degauss   = 1'b0;
		// Degauss: periodic, on wake, or one-shot
		if (sampleTick) begin
			nxt_dgCnt   = dgCnt_ff + 1'b1;
			nxt_degauss = dgDue;
		end
		if (activeMode && magOn && !prevAct_ff) begin
			nxt_degauss = 1'b1;
		end
		if (ctrlOne_ff[CO_RST]) begin
			nxt_degauss = 1'b1;
			nxt_ctrlOne[CO_RST] = 1'b0;
		end
		// One-shot measurement in standby
		if (oneShot) begin
			nxt_ostBusy = 1'b1;
		end
		if (ostBusy_ff && magSampleValid) begin
			nxt_ostBusy = 1'b0;
			nxt_ctrlOne[CO_OST] = 1'b0;
		end
		// Min/max restart completes in one cycle
		if (ctrlTwo_ff[CT_MMRST]) begin
			nxt_ctrlTwo[CT_MMRST] = 1'b0;
		end
		// Host writes win over hardware clears
		if (regWr) begin
			unique case (regAddr)
				OFS_THS_COUNT: nxt_thsCount = regWrData;
				OFS_CTRL_ONE:  nxt_ctrlOne  = regWrData;
				OFS_CTRL_TWO:  nxt_ctrlTwo  = regWrData & CT_MASK;
				default:       ;
			endcase
		end
		// Read data and burst address advance
		if (regRd) begin
			unique case (regAddr)
				OFS_THS_COUNT: nxt_regRdData = thsCount_ff;
				OFS_CTRL_ONE:  nxt_regRdData = ctrlOne_ff;
				OFS_CTRL_TWO:  nxt_regRdData = ctrlTwo_ff;
				default:       nxt_regRdData = 8'h00;
			endcase
			nxt_burstAddr = regAddr + 8'h01;
			if (ctrlTwo_ff[CT_AINC] && !fastRead && regAddr == ADR_NORM_LAST) begin
				nxt_burstAddr = ADR_MAG_FIRST;
			end
			if (ctrlTwo_ff[CT_AINC] && fastRead && regAddr == ADR_FAST_LAST) begin
				nxt_burstAddr = ADR_MAG_FIRST;
			end
		end
	end

	// Register and control flip-flops
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			thsCount_ff  <= RST_THS_COUNT;
			ctrlOne_ff   <= RST_CTRL_ONE;
			ctrlTwo_ff   <= RST_CTRL_TWO;
			regRdData_ff <= 8'h00;
			burstAddr_ff <= 8'h00;
			half_ff      <= 1'b0;
			prevAct_ff   <= 1'b0;
			ostBusy_ff   <= 1'b0;
			meas_ff      <= 1'b0;
			degauss_ff   <= 1'b0;
			dgCnt_ff     <= '0;
		end else begin
			thsCount_ff  <= nxt_thsCount;
			ctrlOne_ff   <= nxt_ctrlOne;
			ctrlTwo_ff   <= nxt_ctrlTwo;
			regRdData_ff <= nxt_regRdData;
			burstAddr_ff <= nxt_burstAddr;
			half_ff      <= nxt_half;
			prevAct_ff   <= nxt_prevAct;
			ostBusy_ff   <= nxt_ostBusy;
			meas_ff      <= nxt_meas;
			degauss_ff   <= nxt_degauss;
			dgCnt_ff     <= nxt_dgCnt;
		end
	end

	// ==========================================================
	// Debounce, min/max tracking and offsets
	logic [7:0]         dbCnt_ff, nxt_dbCnt;
	logic               thsEvt_ff, nxt_thsEvt;
	logic               mode_ff, nxt_mode;
	logic [2:0][SW-1:0] max_ff, nxt_max, min_ff, nxt_min, off_ff, nxt_off;
	logic               sampleEnd, mmRun;
	logic [SW:0]        sum;

	// Sample ends paced by the measurement starts
	assign sampleEnd = magSampleValid && magOn;
	assign mmRun = !ctrlTwo_ff[CT_MMDIS] && !(ctrlTwo_ff[CT_MMTHS] && thsEvt_ff);

	always_comb begin
		nxt_dbCnt  = dbCnt_ff;
		nxt_thsEvt = thsEvt_ff;
		nxt_mode   = magOn ? (hybrid ? HMS_HYBRID[0] : 1'b0) : 1'b0;
		nxt_max    = max_ff;
		nxt_min    = min_ff;
		nxt_off    = off_ff;
		sum        = '0;
		// Debounce count, saturating at the programmed value
		if (!magOn) begin
			nxt_dbCnt = 8'h00;
		end else if (sampleEnd && thsCondition) begin
			if (dbCnt_ff < thsCount_ff) begin
				nxt_dbCnt = dbCnt_ff + 8'h01;
			end else begin
				nxt_dbCnt = thsCount_ff;
			end
			if (nxt_dbCnt == thsCount_ff) begin
				nxt_thsEvt = 1'b1;
			end
		end else if (sampleEnd) begin
			if (debounceClearMode || dbCnt_ff == 8'h00) begin
				nxt_dbCnt = 8'h00;
			end else begin
				nxt_dbCnt = dbCnt_ff - 8'h01;
			end
		end
		// Host clear loses to a simultaneous set
		if (thsFlagClr && !(nxt_thsEvt && !thsEvt_ff)) begin
			nxt_thsEvt = 1'b0;
		end
		// Min/max tracking per axis
		for (int i = 0; i < 3; i++) begin
			if (ctrlTwo_ff[CT_MMRST]) begin
				nxt_min[i] = MIN_START;
				nxt_max[i] = MAX_START;
			end else if (sampleEnd && mmRun) begin
				if ($signed(magSample[i]) > $signed(max_ff[i])) begin
					nxt_max[i] = magSample[i];
				end
				if ($signed(magSample[i]) < $signed(min_ff[i])) begin
					nxt_min[i] = magSample[i];
				end
			end
		end
		// Hard-iron offset from the midpoint of max and min
		if (sampleEnd && ctrlOne_ff[CO_ACAL]) begin
			for (int i = 0; i < 3; i++) begin
				sum = {nxt_max[i][SW-1], nxt_max[i]} + {nxt_min[i][SW-1], nxt_min[i]};
				nxt_off[i] = sum[SW:1];
			end
		end
	end

	// Datapath flip-flops
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			dbCnt_ff  <= 8'h00;
			thsEvt_ff <= 1'b0;
			mode_ff   <= 1'b0;
			max_ff    <= {3{MAX_START}};
			min_ff    <= {3{MIN_START}};
			off_ff    <= '0;
		end else begin
			dbCnt_ff  <= nxt_dbCnt;
			thsEvt_ff <= nxt_thsEvt;
			mode_ff   <= nxt_mode;
			max_ff    <= nxt_max;
			min_ff    <= nxt_min;
			off_ff    <= nxt_off;
		end
	end

	// ==========================================================
	// Outputs, from flip-flops; accelEnable is decoded from the mode bits
	assign regRdData          = regRdData_ff;
	assign burstAddr          = burstAddr_ff;
	assign accelEnable        = !ctrlOne_ff[CO_HMLO] || hms == HMS_HYBRID ? 1'b1 : 1'b0;
	assign magEnable          = ctrlOne_ff[CO_HMLO];
	assign hybridLayout       = mode_ff;
	assign magOversampleRatio = ctrlOne_ff[CO_OSLO +: 3];
	assign measStart          = meas_ff;
	assign degauss            = degauss_ff;
	assign thsEvent           = thsEvt_ff;
	assign debounceCount      = dbCnt_ff;
	assign magOffset          = off_ff;
	assign magMax             = max_ff;
	assign magMin             = min_ff;

	// ==========================================================
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	sequence s_mmReset;
		ctrlTwo_ff[CT_MMRST] ##1 !ctrlTwo_ff[CT_MMRST] || $past(regWr);
	endsequence

	dbSat_a: assert property (dbCnt_ff > $past(dbCnt_ff)
		|-> dbCnt_ff <= $past(thsCount_ff))
		else $error("debounce counter passed its limit");
	dbFlag_a: assert property (magOn && sampleEnd && thsCondition && !regWr
		&& dbCnt_ff + 8'h01 == thsCount_ff |=> thsEvent)
		else $error("event flag not set at count");
	dbLapse_a: assert property (magOn && sampleEnd && !thsCondition && debounceClearMode
		|=> dbCnt_ff == 8'h00)
		else $error("debounce counter not cleared on lapse");
	dbIdle_a: assert property (!magOn |=> dbCnt_ff == 8'h00)
		else $error("debounce counter not held while idle");
	hybHalf_a: assert property (hybrid && sampleTick |=> !sampleTick)
		else $error("hybrid sampled on consecutive ticks");
	burstJump_a: assert property (regRd && ctrlTwo_ff[CT_AINC] && !fastRead
		&& regAddr == ADR_NORM_LAST |=> burstAddr == ADR_MAG_FIRST)
		else $error("burst did not jump to magnetic block");
	burstFast_a: assert property (regRd && ctrlTwo_ff[CT_AINC] && fastRead
		&& regAddr == ADR_FAST_LAST |=> burstAddr == ADR_MAG_FIRST)
		else $error("fast burst did not jump to magnetic block");
	mmReset_a: assert property (s_mmReset |-> magMin[0] == MIN_START
		&& magMax[2] == MAX_START)
		else $error("min/max restart values wrong");
	oneDeg_a: assert property (ctrlOne_ff[CO_RST] |=> degauss ##1 !ctrlOne_ff[CO_RST]
		|| $past(regWr))
		else $error("one-shot degauss did not pulse and clear");
	ostActive_a: assert property (activeMode && !sampleTick |=> !measStart)
		else $error("one-shot measured in active mode");
endmodule
`default_nettype wire

// >>> sim/mcd_sensor_model.sv
// ==========
// Magnetic front-end model: answers each measurement start with one sample.
// Assumes measStart is a one-cycle pulse launched on a rising clock edge.
`default_nettype none
module mcd_sensor_model (
	input  wire logic            core_clk,
	input  wire logic            measStart,
	input  wire logic [3:0]      lat,
	input  wire logic [2:0][15:0] nextSample,
	output logic                 magSampleValid,
	output logic      [2:0][15:0] magSample
);
	timeunit 1ns;
	timeprecision 1ps;
	// Start seen mid-cycle, answer lat edges later; lines turn over between samples
	initial begin
		magSampleValid = 1'b0;
		magSample = '0;
		forever begin
			@(negedge core_clk);
			if (measStart === 1'b1) begin
				repeat (lat) @(posedge core_clk);
				#2;
				magSampleValid = 1'b1;
				magSample = nextSample;
				@(posedge core_clk);
				#2;
				magSampleValid = 1'b0;
				magSample = ~nextSample;
			end
		end
	end
endmodule
`default_nettype wire

// >>> sim/magnetometer_control_debounce_tb.sv
// ==========
// Self-checking bench for the magnetometer control block.
// Assumes the sensor model stands behind measStart and magSampleValid.
`default_nettype none
module magnetometer_control_debounce_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import mcd_pkg::*;
	logic core_clk = 0;
	logic resetn = 0;
	logic regWr = 0, regRd = 0, fastRead = 0, activeMode = 0, odrTick = 0;
	logic thsCondition = 0, debounceClearMode = 0, thsFlagClr = 0;
	logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, burstAddr, debounceCount;
	logic accelEnable, magEnable, hybridLayout, measStart, degauss, thsEvent;
	logic magSampleValid;
	logic [2:0] magOversampleRatio;
	logic [2:0][15:0] magSample, magOffset, magMax, magMin, nextSample = '0;
	logic [3:0] lat = 4'h1;
	int mismatches = 0, checks = 0, dgCount = 0, msCount = 0, dg0 = 0, ms0 = 0;
	mcd_top dut (.core_clk, .resetn, .regWr, .regRd, .regAddr, .regWrData, .regRdData,
		.burstAddr, .fastRead, .activeMode, .odrTick, .thsCondition, .debounceClearMode,
		.thsFlagClr, .magSampleValid, .magSample, .accelEnable, .magEnable, .hybridLayout,
		.magOversampleRatio, .measStart, .degauss, .thsEvent, .debounceCount, .magOffset,
		.magMax, .magMin);
	mcd_sensor_model fe (.core_clk, .measStart, .lat, .nextSample, .magSampleValid,
		.magSample);
	// Clock and pulse counters
	always #20 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		if (degauss === 1'b1) dgCount++;
		if (measStart === 1'b1) msCount++;
	end
	// ==========
	// Shared tasks
	task tick();
		@(posedge core_clk);
		#1;
	endtask
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		regWr = 1;
		regAddr = a;
		regWrData = d;
		tick();
		regWr = 0;
		tick();
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		regRd = 1;
		regAddr = a;
		tick();
		regRd = 0;
		tick();
		chk("regRdData", e, regRdData);
	endtask
	task waitValid();
		int n;
		n = 0;
		while (magSampleValid !== 1'b1 && n < 30) begin
			tick();
			n++;
		end
		if (n >= 30) chk("magSampleValid", 1, 0);
		repeat (2) tick();
	endtask
	task sample(input logic c, input logic [15:0] x, input logic [15:0] y);
		thsCondition = c;
		nextSample = {16'h0000, y, x};
		odrTick = 1;
		tick();
		odrTick = 0;
		waitValid();
	endtask
	task test_done();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ==========
	// Scenarios
	task t_regs();
		rd(OFS_THS_COUNT, RST_THS_COUNT);
		rd(OFS_CTRL_ONE, RST_CTRL_ONE);
		rd(OFS_CTRL_TWO, RST_CTRL_TWO);
		rd(8'h40, 8'h00);
		chk("magMax", MAX_START, magMax[0]);
		chk("magMin", MIN_START, magMin[2]);
		wr(OFS_CTRL_TWO, 8'hF3);
		rd(OFS_CTRL_TWO, 8'h33);
		wr(OFS_CTRL_ONE, 8'h1D);
		chk("oversample", 3'h7, magOversampleRatio);
	endtask
	task t_modes();
		logic [1:0] m;
		for (int i = 0; i < 4; i++) begin
			m = 2'(i);
			wr(OFS_CTRL_ONE, {6'h00, m});
			chk("accelEnable", m != HMS_MAG, accelEnable);
			chk("magEnable", m[0], magEnable);
			chk("hybridLayout", m == HMS_HYBRID, hybridLayout);
		end
		activeMode = 1;
		ms0 = msCount;
		repeat (4) begin
			odrTick = 1;
			tick();
			odrTick = 0;
			repeat (12) tick();
		end
		chk("hybrid starts", 2, 16'(msCount - ms0));
	endtask
	task t_burst();
		rd(ADR_NORM_LAST, 8'h00);
		chk("burstAddr", ADR_MAG_FIRST, burstAddr);
		rd(ADR_FAST_LAST, 8'h00);
		chk("burstAddr", 8'h06, burstAddr);
		fastRead = 1;
		rd(ADR_FAST_LAST, 8'h00);
		chk("burstAddr", ADR_MAG_FIRST, burstAddr);
		fastRead = 0;
		wr(OFS_CTRL_TWO, 8'h03);
		rd(ADR_NORM_LAST, 8'h00);
		chk("burstAddr", 8'h07, burstAddr);
	endtask
	task t_minmax();
		wr(OFS_CTRL_ONE, 8'h81);
		dg0 = dgCount;
		lat = 4'h6;
		sample(0, 16'h0064, 16'hFFCE);
		sample(0, 16'h012C, 16'hFFF6);
		chk("magMax", 16'h012C, magMax[0]);
		chk("magMin", 16'hFFCE, magMin[1]);
		chk("offX", 16'h00C8, magOffset[0]);
		chk("offY", 16'hFFE2, magOffset[1]);
		chk("degauss", 0, 16'(dgCount - dg0));
		wr(OFS_CTRL_TWO, 8'h13);
		sample(0, 16'h0200, 16'h0000);
		chk("magMax", 16'h012C, magMax[0]);
		wr(OFS_CTRL_TWO, 8'h07);
		rd(OFS_CTRL_TWO, 8'h03);
		chk("magMax", MAX_START, magMax[0]);
		chk("magMin", MIN_START, magMin[1]);
	endtask
	task t_debounce();
		wr(OFS_THS_COUNT, 8'h03);
		wr(OFS_CTRL_TWO, 8'h00);
		wr(OFS_CTRL_ONE, 8'h01);
		lat = 4'h1;
		dg0 = dgCount;
		ms0 = msCount;
		for (int i = 1; i <= 4; i++) begin
			sample(1, 16'h0000, 16'h0000);
			chk("debounceCount", (i > 3) ? 3 : i, debounceCount);
			chk("thsEvent", i >= 3, thsEvent);
		end
		chk("starts", 4, 16'(msCount - ms0));
		chk("degauss", 4, 16'(dgCount - dg0));
		sample(0, 16'h0000, 16'h0000);
		chk("debounceCount", 2, debounceCount);
		debounceClearMode = 1;
		sample(0, 16'h0000, 16'h0000);
		chk("debounceCount", 0, debounceCount);
		sample(1, 16'h0000, 16'h0000);
		wr(OFS_CTRL_TWO, 8'h0B);
		sample(1, 16'h0100, 16'h0000);
		chk("magMax", 16'h0000, magMax[0]);
		wr(OFS_CTRL_ONE, 8'h00);
		chk("debounceCount", 0, debounceCount);
		thsFlagClr = 1;
		tick();
		thsFlagClr = 0;
		tick();
		chk("thsEvent", 0, thsEvent);
	endtask
	task t_oneshot();
		activeMode = 0;
		wr(OFS_CTRL_TWO, 8'h03);
		wr(OFS_CTRL_ONE, 8'h21);
		waitValid();
		rd(OFS_CTRL_ONE, 8'h01);
		dg0 = dgCount;
		wr(OFS_CTRL_ONE, 8'h41);
		repeat (2) tick();
		chk("degauss", 1, 16'(dgCount - dg0));
		rd(OFS_CTRL_ONE, 8'h01);
		activeMode = 1;
		wr(OFS_CTRL_ONE, 8'h21);
		repeat (8) tick();
		rd(OFS_CTRL_ONE, 8'h21);
	endtask
	// Wake degauss, then one degauss per 16 and per 512 starts
	task t_degauss();
		wr(OFS_CTRL_ONE, 8'h01);
		activeMode = 0;
		tick();
		dg0 = dgCount;
		activeMode = 1;
		repeat (3) tick();
		chk("wake degauss", 1, 16'(dgCount - dg0));
		wr(OFS_CTRL_TWO, 8'h01);
		dg0 = dgCount;
		repeat (16) sample(0, 16'h0000, 16'h0000);
		chk("degauss 16", 1, 16'(dgCount - dg0));
		wr(OFS_CTRL_TWO, 8'h02);
		dg0 = dgCount;
		repeat (512) sample(0, 16'h0000, 16'h0000);
		chk("degauss 512", 1, 16'(dgCount - dg0));
	endtask
	// Main sequence; the host keeps the raw-mode bit outside this block clear
	initial begin
		repeat (2) @(posedge core_clk);
		#1;
		resetn = 1;
		t_regs();
		t_modes();
		t_burst();
		t_minmax();
		t_debounce();
		t_oneshot();
		t_degauss();
		test_done();
	end
	// Watchdog
	initial begin
		#400000;
		mismatches++;
		test_done();
	end
endmodule
`default_nettype wire
